// file: core/fan_cfg_pkg.sv
// Register map, field positions and reset values of the fan-control configuration group.
// Assumes an 8-bit register port; the serial bus front end delivers decoded accesses.
package fan_cfg_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] ADDR_CONFIG          = 8'h03; // Configuration
  localparam logic [7:0] ADDR_CONV_RATE       = 8'h04; // Conversion rate
  localparam logic [7:0] ADDR_LOCAL_HIGH      = 8'h05; // Local high setpoint
  localparam logic [7:0] ADDR_REMOTE_HIGH     = 8'h07; // Remote high setpoint
  localparam logic [7:0] ADDR_REMOTE_LOW      = 8'h08; // Remote low setpoint
  localparam logic [7:0] ADDR_CONFIG_MIRROR   = 8'h09; // Legacy mirror of 0x03
  localparam logic [7:0] ADDR_CONV_MIRROR     = 8'h0A; // Legacy mirror of 0x04
  localparam logic [7:0] ADDR_LHIGH_MIRROR    = 8'h0B; // Legacy mirror of 0x05
  localparam logic [7:0] ADDR_RHIGH_MIRROR    = 8'h0D; // Legacy mirror of 0x07
  localparam logic [7:0] ADDR_RLOW_MIRROR     = 8'h0E; // Legacy mirror of 0x08
  localparam logic [7:0] ADDR_REMOTE_LSB      = 8'h10; // Remote signed temperature low byte
  localparam logic [7:0] ADDR_COMP_EN         = 8'h30; // Remote diode compensation enable
  localparam logic [7:0] ADDR_POR_STATUS      = 8'h33; // Power-on status
  localparam logic [7:0] ADDR_ENH_CFG         = 8'h45; // Enhanced configuration
  localparam logic [7:0] ADDR_PWM_TACH        = 8'h4A; // PWM and tach configuration
  localparam logic [7:0] ADDR_SPINUP          = 8'h4B; // Fan spin-up configuration
  localparam logic [7:0] ADDR_DUTY            = 8'h4C; // Manual duty value
  localparam logic [7:0] ADDR_PWM_FREQ        = 8'h4D; // PWM frequency setting
  localparam logic [7:0] ADDR_TABLE_OFFSET    = 8'h4E; // Lookup temperature offset
  localparam logic [7:0] ADDR_HYSTERESIS      = 8'h4F; // Lookup hysteresis

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_COMP_EN          = 8'h02;
  localparam logic [7:0] RST_ENH_CFG          = 8'h00;
  localparam logic [7:0] RST_PWM_TACH         = 8'h20;
  localparam logic [7:0] RST_SPINUP           = 8'h3F;
  localparam logic [7:0] RST_DUTY             = 8'h00;
  localparam logic [7:0] RST_PWM_FREQ         = 8'h17;
  localparam logic [7:0] RST_TABLE_OFFSET     = 8'h00;
  localparam logic [7:0] RST_HYSTERESIS       = 8'h04;
  localparam logic [7:0] RST_CONFIG           = 8'h00;
  localparam logic [7:0] RST_CONV_RATE        = 8'h08;
  localparam logic [7:0] RST_LOCAL_HIGH       = 8'h46;
  localparam logic [7:0] RST_REMOTE_HIGH      = 8'h55;
  localparam logic [7:0] RST_REMOTE_LOW       = 8'h00;

  // ==========================================================================
  // Field positions and masks
  // ==========================================================================
  localparam int         UNLOCK_BIT           = 5;      // Fan register write unlock in 0x4A
  localparam int         CLKSEL_BIT           = 3;      // Internal PWM clock select in 0x4A
  localparam logic       CLKSEL_360K          = 1'b0;   // Select value for the fast clock
  localparam int         NOT_READY_BIT        = 7;      // Not-ready flag in 0x33
  localparam int         ENH_SMOOTH_BIT       = 0;      // Smoothing enable in 0x45
  localparam int         ENH_HIGHRES_BIT      = 4;      // High duty resolution in 0x45
  localparam int         ENH_FILTER_LSB_BIT   = 6;      // Signed filter LSB enable in 0x45
  localparam logic [7:0] ENH_WRITABLE_MASK    = 8'h7F;  // Bit 7 unused
  localparam logic [7:0] FINE_LSB_MASK        = 8'h18;  // Signed temperature bits [4:3]
  localparam logic [7:0] DUTY_NORMAL_MASK     = 8'h3F;  // Six-bit duty width
  localparam logic [4:0] FREQ_22K5            = 5'h08;  // 360 kHz / (2 * 8)
  localparam int         LEGACY_N             = 5;      // Registers with a mirror address

endpackage

// file: core/fan_control_init_config.sv
// Fan-control configuration register group with write unlock and mirror decode.
// Assumes the serial bus front end presents one decoded access per strobe on sys_clk.

// Function
// - Frequency field with clock sets PWM rate
// - Smoothing, high resolution only at 22.5 kHz
// - Duty six bits, eight in high resolution
// - Fan writes other than to 0x4A accepted only while unlocked
// - Mirror addresses share primary storage
// - Enhanced bit 7 unused, reads zero
// - Fine temperature bits gated by enable
module fan_control_init_config (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] regAddr,                // Register address of the access
  input  wire logic [7:0] regWdata,               // Write data
  input  wire logic       regWrite,               // Write strobe, one cycle
  input  wire logic       regRead,                // Read strobe, one cycle
  input  wire logic       notReady,               // Power-on not-ready level
  input  wire logic       filterEnable,           // Digital filter enabled level
  input  wire logic [7:0] remoteLsbRaw,           // Raw signed temperature low byte
  output logic      [7:0] regRdata,               // Read data
  output logic            regRvalid,              // Read data valid, one cycle
  output logic            writeRejected,          // Locked write refused, one cycle
  output logic      [7:0] diodeCompCfg,           // Compensation enable register
  output logic      [7:0] enhancedCfg,            // Enhanced configuration
  output logic      [7:0] pwmTachCfg,             // PWM and tach configuration
  output logic      [7:0] spinupCfg,              // Spin-up configuration
  output logic      [7:0] manualDuty,             // Manual duty value
  output logic      [7:0] pwmFreqCfg,             // PWM frequency setting
  output logic      [7:0] tableTempOffset,        // Lookup temperature offset
  output logic      [7:0] tableHysteresis,        // Lookup hysteresis
  output logic            fanRegisterWriteUnlock, // Copy of the unlock bit
  output logic            smoothingActive,        // Table smoothing in effect
  output logic            highResActive           // Extended duty resolution in effect
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [7:0] LEGACY_ADDR [fan_cfg_pkg::LEGACY_N] = '{
    fan_cfg_pkg::ADDR_CONFIG, fan_cfg_pkg::ADDR_CONV_RATE, fan_cfg_pkg::ADDR_LOCAL_HIGH,
    fan_cfg_pkg::ADDR_REMOTE_HIGH, fan_cfg_pkg::ADDR_REMOTE_LOW};
  localparam logic [7:0] LEGACY_RST  [fan_cfg_pkg::LEGACY_N] = '{
    fan_cfg_pkg::RST_CONFIG, fan_cfg_pkg::RST_CONV_RATE, fan_cfg_pkg::RST_LOCAL_HIGH,
    fan_cfg_pkg::RST_REMOTE_HIGH, fan_cfg_pkg::RST_REMOTE_LOW};

  logic [7:0] primaryAddr;                          // Address after mirror folding
  logic [7:0] legacy      [fan_cfg_pkg::LEGACY_N];  // Mirrored storage
  logic [7:0] next_legacy [fan_cfg_pkg::LEGACY_N];
  logic [7:0] next_regRdata;
  logic       next_regRvalid;
  logic       next_writeRejected;
  logic [7:0] next_diodeCompCfg;
  logic [7:0] next_enhancedCfg;
  logic [7:0] next_pwmTachCfg;
  logic [7:0] next_spinupCfg;
  logic [7:0] next_manualDuty;
  logic [7:0] next_pwmFreqCfg;
  logic [7:0] next_tableTempOffset;
  logic [7:0] next_tableHysteresis;
  logic       next_smoothingActive;
  logic       next_highResActive;
  logic       unlocked;                             // Fan registers writable now
  logic       is22k5;                               // 22.5 kHz PWM selected
  logic       fineLsbOn;                            // Fine temperature bits visible

  // Mirror addresses reduced to primaries before any decode
  mirror_decode u_mirror (
    .rawAddr     (regAddr),
    .primaryAddr (primaryAddr)
  );

  // ==========================================================================
  // Next-value logic
  // ==========================================================================
  // Writes, reads and derived modes in one place so priorities stay visible
  always_comb begin
    next_legacy          = legacy;
    next_diodeCompCfg    = diodeCompCfg;
    next_enhancedCfg     = enhancedCfg;
    next_pwmTachCfg      = pwmTachCfg;
    next_spinupCfg       = spinupCfg;
    next_manualDuty      = manualDuty;
    next_pwmFreqCfg      = pwmFreqCfg;
    next_tableTempOffset = tableTempOffset;
    next_tableHysteresis = tableHysteresis;
    next_writeRejected   = 1'b0;
    next_regRvalid       = regRead;
    next_regRdata        = regRdata;
    unlocked  = pwmTachCfg[fan_cfg_pkg::UNLOCK_BIT];
    // PWM rate comes from the frequency field and the clock select together
    is22k5    = (pwmTachCfg[fan_cfg_pkg::CLKSEL_BIT] == fan_cfg_pkg::CLKSEL_360K) &&
                (pwmFreqCfg[4:0] == fan_cfg_pkg::FREQ_22K5);
    fineLsbOn = enhancedCfg[fan_cfg_pkg::ENH_FILTER_LSB_BIT] && filterEnable;
    // Smoothing and high resolution only take effect at 22.5 kHz
    next_smoothingActive = enhancedCfg[fan_cfg_pkg::ENH_SMOOTH_BIT] && is22k5;
    next_highResActive   = enhancedCfg[fan_cfg_pkg::ENH_HIGHRES_BIT] && is22k5;

    // Write decode; the unlock register itself is never locked
    if (regWrite) begin
      case (primaryAddr)
        fan_cfg_pkg::ADDR_COMP_EN : begin
          next_diodeCompCfg = regWdata;
        end
        fan_cfg_pkg::ADDR_PWM_TACH : begin
          // Tach, clock select, polarity and unlock
          next_pwmTachCfg = regWdata;
        end
        fan_cfg_pkg::ADDR_ENH_CFG : begin
          if (unlocked) begin
            next_enhancedCfg = regWdata & fan_cfg_pkg::ENH_WRITABLE_MASK;
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        fan_cfg_pkg::ADDR_SPINUP : begin
          if (unlocked) begin
            next_spinupCfg = regWdata;
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        fan_cfg_pkg::ADDR_DUTY : begin
          // Width follows the resolution actually in effect
          if (unlocked) begin
            next_manualDuty = highResActive ? regWdata
                                            : (regWdata & fan_cfg_pkg::DUTY_NORMAL_MASK);
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        fan_cfg_pkg::ADDR_PWM_FREQ : begin
          if (unlocked) begin
            next_pwmFreqCfg = regWdata;
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        fan_cfg_pkg::ADDR_TABLE_OFFSET : begin
          if (unlocked) begin
            next_tableTempOffset = regWdata;
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        fan_cfg_pkg::ADDR_HYSTERESIS : begin
          if (unlocked) begin
            next_tableHysteresis = regWdata;
          end else begin
            next_writeRejected = 1'b1;
          end
        end
        default : begin
          // Mirrored group; unmapped writes fall through silently
          for (int i = 0; i < fan_cfg_pkg::LEGACY_N; i++) begin
            if (primaryAddr == LEGACY_ADDR[i]) begin
              next_legacy[i] = regWdata;
            end
          end
        end
      endcase
    end

    // Read mux; unmapped addresses answer zero
    if (regRead) begin
      case (primaryAddr)
        fan_cfg_pkg::ADDR_POR_STATUS   : next_regRdata = {notReady, 7'h00};
        fan_cfg_pkg::ADDR_REMOTE_LSB   : begin
          next_regRdata = fineLsbOn ? remoteLsbRaw
                                    : (remoteLsbRaw & ~fan_cfg_pkg::FINE_LSB_MASK);
        end
        fan_cfg_pkg::ADDR_COMP_EN      : next_regRdata = diodeCompCfg;
        fan_cfg_pkg::ADDR_ENH_CFG      : next_regRdata = enhancedCfg & fan_cfg_pkg::ENH_WRITABLE_MASK;
        fan_cfg_pkg::ADDR_PWM_TACH     : next_regRdata = pwmTachCfg;
        fan_cfg_pkg::ADDR_SPINUP       : next_regRdata = spinupCfg;
        fan_cfg_pkg::ADDR_DUTY         : next_regRdata = manualDuty;
        fan_cfg_pkg::ADDR_PWM_FREQ     : next_regRdata = pwmFreqCfg;
        fan_cfg_pkg::ADDR_TABLE_OFFSET : next_regRdata = tableTempOffset;
        fan_cfg_pkg::ADDR_HYSTERESIS   : next_regRdata = tableHysteresis;
        default : begin
          next_regRdata = 8'h00;
          for (int i = 0; i < fan_cfg_pkg::LEGACY_N; i++) begin
            if (primaryAddr == LEGACY_ADDR[i]) begin
              next_regRdata = legacy[i];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  // Reset loads power-on values; the host sequence starts from the unlocked default
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      legacy                 <= LEGACY_RST;
      regRdata               <= 8'h00;
      regRvalid              <= 1'b0;
      writeRejected          <= 1'b0;
      diodeCompCfg           <= fan_cfg_pkg::RST_COMP_EN;
      enhancedCfg            <= fan_cfg_pkg::RST_ENH_CFG;
      pwmTachCfg             <= fan_cfg_pkg::RST_PWM_TACH;
      spinupCfg              <= fan_cfg_pkg::RST_SPINUP;
      manualDuty             <= fan_cfg_pkg::RST_DUTY;
      pwmFreqCfg             <= fan_cfg_pkg::RST_PWM_FREQ;
      tableTempOffset        <= fan_cfg_pkg::RST_TABLE_OFFSET;
      tableHysteresis        <= fan_cfg_pkg::RST_HYSTERESIS;
      fanRegisterWriteUnlock <= fan_cfg_pkg::RST_PWM_TACH[fan_cfg_pkg::UNLOCK_BIT];
      smoothingActive        <= 1'b0;
      highResActive          <= 1'b0;
    end else begin
      legacy                 <= next_legacy;
      regRdata               <= next_regRdata;
      regRvalid              <= next_regRvalid;
      writeRejected          <= next_writeRejected;
      diodeCompCfg           <= next_diodeCompCfg;
      enhancedCfg            <= next_enhancedCfg;
      pwmTachCfg             <= next_pwmTachCfg;
      spinupCfg              <= next_spinupCfg;
      manualDuty             <= next_manualDuty;
      pwmFreqCfg             <= next_pwmFreqCfg;
      tableTempOffset        <= next_tableTempOffset;
      tableHysteresis        <= next_tableHysteresis;
      fanRegisterWriteUnlock <= next_pwmTachCfg[fan_cfg_pkg::UNLOCK_BIT];
      smoothingActive        <= next_smoothingActive;
      highResActive          <= next_highResActive;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Mirror write, one quiet cycle, then a primary read
  sequence mirrorWrite;
    regWrite && !regRead && (regAddr == fan_cfg_pkg::ADDR_CONFIG_MIRROR);
  endsequence
  sequence primaryRead;
    regRead && !regWrite && (regAddr == fan_cfg_pkg::ADDR_CONFIG);
  endsequence

  a_mirror_shared_store: assert property (mirrorWrite ##1 !regWrite ##1 primaryRead |=>
      regRdata == $past(regWdata, 3)) else $error("mirror and primary differ");
  a_locked_spinup_hold: assert property (regWrite && !unlocked &&
      primaryAddr == fan_cfg_pkg::ADDR_SPINUP |=> $stable(spinupCfg) && writeRejected)
      else $error("locked spin-up write took effect");
  a_unlocked_freq_take: assert property (regWrite && unlocked &&
      primaryAddr == fan_cfg_pkg::ADDR_PWM_FREQ |=> pwmFreqCfg == $past(regWdata))
      else $error("unlocked frequency write lost");
  a_unlock_bit_copy: assert property (regWrite && primaryAddr == fan_cfg_pkg::ADDR_PWM_TACH
      |=> fanRegisterWriteUnlock == $past(regWdata[5])) else $error("unlock copy wrong");
  a_enh_top_zero: assert property (regRead && regAddr == fan_cfg_pkg::ADDR_ENH_CFG
      |=> regRvalid && !regRdata[7]) else $error("enhanced bit 7 read as one");
  a_lsb_masked_off: assert property (regRead && regAddr == fan_cfg_pkg::ADDR_REMOTE_LSB &&
      !fineLsbOn |=> regRdata[4:3] == 2'h0) else $error("fine bits leaked");
  a_lsb_fine_pass: assert property (regRead && regAddr == fan_cfg_pkg::ADDR_REMOTE_LSB &&
      fineLsbOn |=> regRdata[4:3] == $past(remoteLsbRaw[4:3])) else $error("fine bits lost");
  a_duty_narrow_width: assert property (regWrite && unlocked && !highResActive &&
      primaryAddr == fan_cfg_pkg::ADDR_DUTY |=> manualDuty[7:6] == 2'h0)
      else $error("duty wider than six bits");
  a_highres_needs_22k5: assert property (highResActive |->
      $past(is22k5) && $past(enhancedCfg[4])) else $error("high resolution off 22.5 kHz");
  a_smooth_needs_22k5: assert property (!is22k5 ##1 !is22k5 |-> !smoothingActive)
      else $error("smoothing off 22.5 kHz");

endmodule

// file: core/mirror_decode.sv
// Folds each legacy mirror address onto its primary address.
// Assumes the caller decodes the primary address only.
module mirror_decode (
  input  wire logic [7:0] rawAddr,
  output logic      [7:0] primaryAddr
);

  // ==========================================================================
  // Mirror folding
  // ==========================================================================
  // Both addresses then reach one storage element
  always_comb begin
    case (rawAddr)
      fan_cfg_pkg::ADDR_CONFIG_MIRROR : primaryAddr = fan_cfg_pkg::ADDR_CONFIG;
      fan_cfg_pkg::ADDR_CONV_MIRROR   : primaryAddr = fan_cfg_pkg::ADDR_CONV_RATE;
      fan_cfg_pkg::ADDR_LHIGH_MIRROR  : primaryAddr = fan_cfg_pkg::ADDR_LOCAL_HIGH;
      fan_cfg_pkg::ADDR_RHIGH_MIRROR  : primaryAddr = fan_cfg_pkg::ADDR_REMOTE_HIGH;
      fan_cfg_pkg::ADDR_RLOW_MIRROR   : primaryAddr = fan_cfg_pkg::ADDR_REMOTE_LOW;
      default                         : primaryAddr = rawAddr;
    endcase
  end

endmodule

// file: testbench/host_model.sv
// Host firmware model: drives the register port of the fan configuration group.
// Assumes the bench calls its tasks; strobes change only at falling edges.
module host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWrite,
  output logic            regRead
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  // Idle port at time zero
  initial begin
    regAddr  = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end
  // One write pulse; released lines show the inverse so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask
  // One read pulse, answer awaited for a bounded number of cycles
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
    int n;
    @(negedge sys_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    regAddr = ~a;
    ok      = 1'b0;
    q       = 8'h00;
    for (n = 0; n < 3 && !ok; n++) begin
      if (regRvalid === 1'b1) begin
        q  = regRdata;
        ok = 1'b1;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask
  // Ordered setup; the poll is bounded so a stuck flag ends in a failure
  task automatic init_seq(input logic [7:0] comp, pwm, spin, freq, enh, duty,
                          output logic ok);
    logic [7:0] st;
    int         n;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      rd(8'h33, st, ok);
      ok = ok && (st[7] === 1'b0);
    end
    if (ok) begin
      wr(8'h30, comp);
      wr(8'h4A, pwm);
      wr(8'h4B, spin);
      wr(8'h4D, freq);
      wr(8'h45, enh);
      wr(8'h4C, duty);
    end
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench of the fan configuration register group.
// Assumes host_model drives the register port; bench drives status inputs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, srst, notReady, filterEnable, ok;
  logic [7:0] remoteLsbRaw, regAddr, regWdata, regRdata, q, d;
  logic       regWrite, regRead, regRvalid, writeRejected, smooth, hiRes, unlock;
  int         failCount = 0, numChecks = 0, rejCount = 0, i, r0;
  integer     seed = 32'he6e7;
  // Address and reset value pairs, then mirror pairs
  logic [15:0] rstTab [16] = '{16'h3002, 16'h4500, 16'h4A20, 16'h4B3F, 16'h4C00,
    16'h4D17, 16'h4E00, 16'h4F04, 16'h0300, 16'h0408, 16'h0546, 16'h0755,
    16'h0800, 16'h4000, 16'h5000, 16'h3380};
  logic [15:0] mir [5] = '{16'h0309, 16'h040A, 16'h050B, 16'h070D, 16'h080E};
  logic [7:0]  lockd [6] = '{8'h45, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F};
  logic [7:0]  cfgOut [8]; // Configuration outputs, in the order of rstTab
  // ==========================================================================
  // Clock, instances, monitors
  // ==========================================================================
  always #12.5 sys_clk = ~sys_clk;
  // Refusal pulses counted on each falling edge
  always @(negedge sys_clk) if (writeRejected === 1'b1) rejCount <= rejCount + 1;
  fan_control_init_config dut_u (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .notReady(notReady),
    .filterEnable(filterEnable), .remoteLsbRaw(remoteLsbRaw), .regRdata(regRdata),
    .regRvalid(regRvalid), .writeRejected(writeRejected), .diodeCompCfg(cfgOut[0]),
    .enhancedCfg(cfgOut[1]), .pwmTachCfg(cfgOut[2]), .spinupCfg(cfgOut[3]),
    .manualDuty(cfgOut[4]), .pwmFreqCfg(cfgOut[5]), .tableTempOffset(cfgOut[6]),
    .tableHysteresis(cfgOut[7]), .fanRegisterWriteUnlock(unlock),
    .smoothingActive(smooth), .highResActive(hiRes));
  host_model hostU (.sys_clk(sys_clk), .regRdata(regRdata), .regRvalid(regRvalid),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead));
  // ==========================================================================
  // Expectations and checks
  // ==========================================================================
  // Fine bits pass only with the enable and the filter both on
  function automatic logic [7:0] expLsb(logic [7:0] raw, logic en, logic filt);
    return (en && filt) ? raw : (raw & 8'hE7);
  endfunction
  // Narrow duty keeps six bits
  function automatic logic [7:0] expDuty(logic [7:0] v, logic hr);
    return hr ? v : (v & 8'h3F);
  endfunction
  task automatic tally_and_finish();
    if (failCount == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read and compare; a missing answer ends the run
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    hostU.rd(a, q, ok);
    if (ok !== 1'b1) begin
      failCount++;
      $display("MISMATCH %0t no read answer", $time);
      tally_and_finish();
    end else begin
      chk(q, exp);
    end
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    notReady = 1'b1;
    filterEnable = 1'b0;
    remoteLsbRaw = 8'h00;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    for (i = 0; i < 16; i++) rchk(rstTab[i][15:8], rstTab[i][7:0]);
    for (i = 0; i < 8; i++) chk(cfgOut[i], rstTab[i][7:0]);
    notReady = 1'b0;
    hostU.init_seq(8'h00, 8'h20, 8'h15, 8'h08, 8'h91, 8'hFF, ok);
    chk({7'h00, ok}, 8'h01);
    chk(cfgOut[3], 8'h15);
    chk(cfgOut[5], 8'h08);
    chk(cfgOut[1], 8'h11);
    chk(cfgOut[4], 8'hFF);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, smooth, hiRes}, 8'h03);
    rchk(8'h45, 8'h11);
    rchk(8'h4C, expDuty(8'hFF, 1'b1));
    rchk(8'h4B, 8'h15);
    hostU.wr(8'h4D, 8'h17);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, smooth, hiRes}, 8'h00);
    hostU.wr(8'h4D, 8'h08);
    hostU.wr(8'h4A, 8'h28);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, smooth, hiRes}, 8'h00);
    hostU.wr(8'h4A, 8'h20);
    hostU.wr(8'h45, 8'h00);
    d = 8'($random(seed));
    hostU.wr(8'h4C, d);
    rchk(8'h4C, expDuty(d, 1'b0));
    for (i = 0; i < 4; i++) begin
      remoteLsbRaw = 8'($random(seed)) | 8'h18;
      hostU.wr(8'h45, {1'b0, i[1], 6'h00});
      filterEnable = i[0];
      rchk(8'h10, expLsb(remoteLsbRaw, i[1], i[0]));
    end
    for (i = 0; i < 10; i++) begin
      d = 8'($random(seed));
      hostU.wr(i[0] ? mir[i / 2][15:8] : mir[i / 2][7:0], d);
      rchk(i[0] ? mir[i / 2][7:0] : mir[i / 2][15:8], d);
    end
    hostU.wr(8'h4A, 8'h00);
    chk({7'h00, unlock}, 8'h00);
    r0 = rejCount;
    for (i = 0; i < 6; i++) begin
      hostU.rd(lockd[i], d, ok);
      chk({7'h00, ok}, 8'h01);
      hostU.wr(lockd[i], ~d);
      rchk(lockd[i], d);
    end
    chk(8'(rejCount - r0), 8'h06);
    hostU.wr(8'h30, 8'h02);
    rchk(8'h30, 8'h02);
    hostU.wr(8'h4A, 8'h20);
    hostU.wr(8'h4E, 8'h5A);
    rchk(8'h4E, 8'h5A);
    chk(cfgOut[6], 8'h5A);
    chk(cfgOut[7], 8'h04);
    chk(cfgOut[0], 8'h02);
    chk(cfgOut[2], 8'h20);
    tally_and_finish();
  end
endmodule
